//--- logic/hcl_defs.svh
// Constants for the hub configuration loader
`ifndef HCL_DEFS_SVH
`define HCL_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define HCL_REG_POWER   8'h00
`define HCL_REG_STATUS  8'h04
`define HCL_REG_VENDOR  8'h08
`define HCL_REG_PRODUCT 8'h0C
`define HCL_REG_OCFLAG  8'h10

// ----------------------------------------------------------------
// Identity values used without memory (values are arbitrary)
// ----------------------------------------------------------------
`define HCL_GENERIC_VENDOR  16'h1234
`define HCL_GENERIC_PRODUCT 16'h5678

// ----------------------------------------------------------------
// Serial memory frame
// ----------------------------------------------------------------
`define HCL_CMD_BITS    6'h08
`define HCL_CMD_WORD    8'hC0
`define HCL_DUMMY_BIT   6'h08
`define HCL_LAST_BIT    6'h38
`define HCL_LAST_CMD    6'h07
`define HCL_SETTLE_MAX  2'h3
`define HCL_PH_DRIVE    2'h0
`define HCL_PH_SAMPLE   2'h1
`define HCL_PH_RISE     2'h2
`define HCL_PH_END      2'h3
`define HCL_GANG_BIT    46
`define HCL_VENDOR_HI   31
`define HCL_VENDOR_LO   16
`define HCL_PRODUCT_HI  15
`define HCL_PRODUCT_LO  0

`endif

//--- logic/hcl_pkg.sv
// Types shared by the hub configuration loader
package hcl_pkg;

    typedef enum logic [1:0] {
        HCL_LK_SETTLE,
        HCL_LK_RUN,
        HCL_LK_DONE
    } hcl_link_state_t;

    typedef struct packed {
        logic        valid;
        logic        gang;
        logic        bus_powered;
        logic        fast_clock;
        logic [15:0] vendor_identifier;
        logic [15:0] product_identifier;
    } hcl_cfg_t;

endpackage

//--- logic/hcl_loader.sv
// Hub start-up configuration loader with serial memory read and port power control
//
// How it works
// RQ1: Select high: generic product id, clock pin idle, data pin gives gang mode.
// RQ2: Select low: pins become memory clock and data; ids come from memory.
// RQ3: Pulldowns enabled only while memory interface is enabled.
// RQ4: One read sequence after reset, only with select low, never repeated.
// RQ5: Send start bit 1, opcode 10, address 00000 on the data line.
// RQ6: Release data line after the address; memory drives it afterwards.
// RQ7: Memory sends dummy zero then three 16-bit words, MSB first.
// RQ8: Device makes the memory clock; memory changes data on rising edges.
// RQ9: Memory auto-increments its address during the continuous read.
// RQ10: After three words both pins float with pulldowns active.
// RQ11: Word 0 bit 14 is gang, word 1 vendor id, word 2 product id.
// RQ12: Gang mode: all enables switch together; any overcurrent removes all power.
// RQ13: Individual mode: each enable and overcurrent input acts on its own port.
// RQ14: Power switch signals overcurrent by pulling its input low.
// RQ15: Four power configurations: bus/self powered crossed with ganged/individual.
// RQ16: Bus-power pin selects bus-powered or self-powered operation.
// RQ17: Select and fast clock input low: 6 MHz crystal clocking.
// RQ18: Select and crystal input high: 48 MHz oscillator on fast clock input.
// RQ19: Captured ids and gang kept from enumeration until next power-on reset; with select high the code keeps gang following the data pin.
`timescale 1ns/1ps
`include "hcl_defs.svh"

module hcl_loader (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              link_clk_in,
    input  wire logic              ext_memory_select_in,
    input  wire logic              bus_power_select_in,
    input  wire logic              clock_source_select_in,
    input  wire logic              crystal_in_in,
    input  wire logic              fast_clock_input_in,
    input  wire logic              serial_mem_data_in,
    output logic                   serial_mem_data_out,
    output logic                   serial_mem_data_oe_out,
    output logic                   serial_mem_clock_out,
    output logic                   serial_mem_clock_oe_out,
    output logic                   serial_mem_pulldown_en_out,
    input  wire logic [3:0]        overcurrent_in_n_in,
    output logic      [3:0]        port_power_enable_n_out,
    output hcl_pkg::hcl_cfg_t      cfg_out,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_write_in,
    input  wire logic              reg_read_in,
    output logic      [31:0]       reg_rdata_out
);

    // ----------------------------------------------------------------
    // Link domain: reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0]              lrst_q;
    logic                    lrst_n;
    logic [1:0]              lsel_q;
    logic [1:0]              ldat_q;
    hcl_pkg::hcl_link_state_t lstate_q;
    logic [1:0]              settle_q;
    logic [1:0]              ph_q;
    logic [5:0]              bit_q;
    logic [47:0]             shift_q;
    logic                    ldone_q;

    always_ff @(posedge link_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end
    assign lrst_n = lrst_q[1];

    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            lsel_q <= 2'h3;
            ldat_q <= 2'h0;
        end else begin
            lsel_q <= {lsel_q[0], ext_memory_select_in};
            ldat_q <= {ldat_q[0], serial_mem_data_in};
        end
    end

    // ----------------------------------------------------------------
    // Link domain: one-shot read sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            lstate_q <= hcl_pkg::HCL_LK_SETTLE;
            settle_q <= 2'h0;
            ph_q     <= 2'h0;
            bit_q    <= 6'h00;
            ldone_q  <= 1'b0;
        end else begin
            case (lstate_q)
                hcl_pkg::HCL_LK_SETTLE: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == `HCL_SETTLE_MAX) begin
                        // Read only with the memory selected; otherwise never start
                        if (!lsel_q[1]) begin  // see RQ4, RQ2
                            lstate_q <= hcl_pkg::HCL_LK_RUN;
                        end else begin
                            lstate_q <= hcl_pkg::HCL_LK_DONE;  // see RQ1
                        end
                    end
                end
                hcl_pkg::HCL_LK_RUN: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == `HCL_PH_END) begin
                        bit_q <= bit_q + 6'h01;
                        if (bit_q == `HCL_LAST_BIT) begin
                            lstate_q <= hcl_pkg::HCL_LK_DONE;  // see RQ4
                            ldone_q  <= 1'b1;
                        end
                    end
                end
                default: begin
                    lstate_q <= hcl_pkg::HCL_LK_DONE;
                end
            endcase
        end
    end

    // Memory clock high in the last two quarters of each bit
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            serial_mem_clock_out    <= 1'b0;
            serial_mem_clock_oe_out <= 1'b0;
        end else begin
            serial_mem_clock_out <= (lstate_q == hcl_pkg::HCL_LK_RUN) &&
                                    (ph_q == `HCL_PH_SAMPLE || ph_q == `HCL_PH_RISE);  // see RQ8
            serial_mem_clock_oe_out <= (lstate_q == hcl_pkg::HCL_LK_RUN) &&
                                       !(bit_q == `HCL_LAST_BIT && ph_q == `HCL_PH_END);  // see RQ10
        end
    end

    // Command bits change while the clock is low; drive ends one link clock after the last address rise
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            serial_mem_data_out    <= 1'b0;
            serial_mem_data_oe_out <= 1'b0;
        end else begin
            if (lstate_q == hcl_pkg::HCL_LK_RUN && bit_q < `HCL_CMD_BITS) begin
                if (ph_q == `HCL_PH_DRIVE) begin
                    serial_mem_data_out    <= cmd_bit(bit_q);  // see RQ5
                    serial_mem_data_oe_out <= 1'b1;
                end
                if (bit_q == `HCL_LAST_CMD && ph_q == `HCL_PH_RISE) begin
                    serial_mem_data_out    <= 1'b0;
                    serial_mem_data_oe_out <= 1'b0;  // see RQ6
                end
            end else begin
                serial_mem_data_out    <= 1'b0;
                serial_mem_data_oe_out <= 1'b0;  // see RQ10
            end
        end
    end

    function automatic logic cmd_bit(input logic [5:0] idx);
        logic [7:0] word;
        word    = `HCL_CMD_WORD;
        cmd_bit = word[3'(`HCL_LAST_CMD - idx)];
    endfunction

    // Sample just before the rise; skip the dummy bit
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            shift_q <= 48'h0;
        end else if (lstate_q == hcl_pkg::HCL_LK_RUN && ph_q == `HCL_PH_SAMPLE &&
                     bit_q > `HCL_DUMMY_BIT) begin
            shift_q <= {shift_q[46:0], ldat_q[1]};  // see RQ7, RQ9
        end
    end

    // ----------------------------------------------------------------
    // Core domain: synchronisers
    // ----------------------------------------------------------------
    logic [1:0] csel_q;
    logic [1:0] cbus_q;
    logic [1:0] csrc_q;
    logic [1:0] cxtal_q;
    logic [1:0] cfast_q;
    logic [1:0] cgang_q;
    logic [1:0] cdone_q;
    logic [3:0] coc1_q;
    logic [3:0] coc2_q;
    logic [1:0] csettle_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            csel_q  <= 2'h3;
            cbus_q  <= 2'h0;
            csrc_q  <= 2'h0;
            cxtal_q <= 2'h0;
            cfast_q <= 2'h0;
            cgang_q <= 2'h0;
            cdone_q <= 2'h0;
            coc1_q  <= 4'hF;
            coc2_q  <= 4'hF;
        end else begin
            csel_q  <= {csel_q[0], ext_memory_select_in};
            cbus_q  <= {cbus_q[0], bus_power_select_in};
            csrc_q  <= {csrc_q[0], clock_source_select_in};
            cxtal_q <= {cxtal_q[0], crystal_in_in};
            cfast_q <= {cfast_q[0], fast_clock_input_in};
            cgang_q <= {cgang_q[0], serial_mem_data_in};
            cdone_q <= {cdone_q[0], ldone_q};
            coc1_q  <= overcurrent_in_n_in;
            coc2_q  <= coc1_q;
        end
    end

    // ----------------------------------------------------------------
    // Core domain: configuration capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            csettle_q <= 2'h0;
        end else if (csettle_q != `HCL_SETTLE_MAX) begin
            csettle_q <= csettle_q + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_out <= '0;
        end else begin
            cfg_out.bus_powered <= cbus_q[1];  // see RQ16, RQ15
            cfg_out.fast_clock  <= csrc_q[1] & cxtal_q[1];  // see RQ18, RQ17
            if (csettle_q == `HCL_SETTLE_MAX && csel_q[1]) begin
                cfg_out.valid              <= 1'b1;
                cfg_out.gang               <= cgang_q[1];  // see RQ1
                cfg_out.vendor_identifier  <= `HCL_GENERIC_VENDOR;
                cfg_out.product_identifier <= `HCL_GENERIC_PRODUCT;
            end else if (cdone_q[1] && !cfg_out.valid) begin
                // Shift data is stable once the done level has crossed
                cfg_out.valid              <= 1'b1;  // see RQ19
                cfg_out.gang               <= shift_q[`HCL_GANG_BIT];  // see RQ11
                cfg_out.vendor_identifier  <= shift_q[`HCL_VENDOR_HI:`HCL_VENDOR_LO];
                cfg_out.product_identifier <= shift_q[`HCL_PRODUCT_HI:`HCL_PRODUCT_LO];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            serial_mem_pulldown_en_out <= 1'b0;
        end else begin
            serial_mem_pulldown_en_out <= !csel_q[1];  // see RQ3, RQ10
        end
    end

    // ----------------------------------------------------------------
    // Core domain: port power and registers
    // ----------------------------------------------------------------
    logic [3:0] power_req_q;
    logic [3:0] oc_flag_q;
    logic [3:0] oc_act;
    logic [3:0] power_on;

    assign oc_act = ~coc2_q;  // see RQ14

    always_comb begin
        if (cfg_out.gang) begin
            power_on = {4{power_req_q[0] & ~|oc_act}};  // see RQ12
        end else begin
            power_on = power_req_q & ~oc_act;  // see RQ13
        end
        if (!cfg_out.valid) begin
            power_on = 4'h0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port_power_enable_n_out <= 4'hF;
        end else begin
            port_power_enable_n_out <= ~power_on;  // see RQ12, RQ13
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            power_req_q <= 4'h0;
        end else if (reg_write_in && reg_addr_in == `HCL_REG_POWER) begin
            power_req_q <= reg_wdata_in[3:0];
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oc_flag_q <= 4'h0;
        end else if (reg_write_in && reg_addr_in == `HCL_REG_OCFLAG) begin
            oc_flag_q <= (oc_flag_q & ~reg_wdata_in[3:0]) | oc_act;
        end else begin
            oc_flag_q <= oc_flag_q | oc_act;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_read_in) begin
            if (reg_addr_in == `HCL_REG_POWER) begin
                reg_rdata_out <= {28'h0, power_req_q};
            end else if (reg_addr_in == `HCL_REG_STATUS) begin
                reg_rdata_out <= {26'h0, cfg_out.fast_clock, cfg_out.bus_powered, cfg_out.gang,
                                  cfg_out.valid, csel_q[1], cfast_q[1]};
            end else if (reg_addr_in == `HCL_REG_VENDOR) begin
                reg_rdata_out <= {16'h0, cfg_out.vendor_identifier};
            end else if (reg_addr_in == `HCL_REG_PRODUCT) begin
                reg_rdata_out <= {16'h0, cfg_out.product_identifier};
            end else if (reg_addr_in == `HCL_REG_OCFLAG) begin
                reg_rdata_out <= {28'h0, oc_flag_q};
            end else begin
                reg_rdata_out <= 32'h0;
            end
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_rise_edge;
        $rose(serial_mem_clock_out);
    endsequence

    a_data_release: assert property (@(posedge link_clk_in) disable iff (!lrst_n)  // see RQ6
        (bit_q > `HCL_CMD_BITS) |-> !serial_mem_data_oe_out)
        else $error("data line driven after the address");

    a_cmd_value: assert property (@(posedge link_clk_in) disable iff (!lrst_n)  // see RQ5
        (lstate_q == hcl_pkg::HCL_LK_RUN && bit_q <= `HCL_LAST_CMD && ph_q == `HCL_PH_RISE)
        |-> serial_mem_data_oe_out && serial_mem_data_out == cmd_bit(bit_q))
        else $error("command bit wrong at clock rise");

    a_no_restart: assert property (@(posedge link_clk_in) disable iff (!lrst_n)  // see RQ4
        (lstate_q == hcl_pkg::HCL_LK_DONE) |=> (lstate_q == hcl_pkg::HCL_LK_DONE) && !serial_mem_clock_oe_out)
        else $error("read sequence restarted");

    a_clock_period: assert property (@(posedge link_clk_in) disable iff (!lrst_n)  // see RQ8
        s_rise_edge |-> serial_mem_clock_out [*2] ##1 !serial_mem_clock_out [*2])
        else $error("memory clock shape wrong");

    a_pins_float: assert property (@(posedge clk_in) disable iff (!rstn_in)  // see RQ10
        cdone_q[1] |-> !serial_mem_data_oe_out && !serial_mem_clock_oe_out && serial_mem_pulldown_en_out)
        else $error("memory pins not released after read");

    a_pulldown_sel: assert property (@(posedge clk_in) disable iff (!rstn_in)  // see RQ3
        ##1 serial_mem_pulldown_en_out == !$past(csel_q[1]))
        else $error("pulldown enable does not follow select");

    a_gang_off: assert property (@(posedge clk_in) disable iff (!rstn_in)  // see RQ12
        (cfg_out.gang && |oc_act) |=> port_power_enable_n_out == 4'hF)
        else $error("ganged ports not all off on overcurrent");

    a_port_off: assert property (@(posedge clk_in) disable iff (!rstn_in)  // see RQ13
        (!cfg_out.gang && cfg_out.valid) |=> port_power_enable_n_out == ~$past(power_req_q & ~oc_act))
        else $error("individual port power wrong");

    a_cfg_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)  // see RQ19
        cfg_out.valid |=> cfg_out.valid && $stable(cfg_out.product_identifier) &&
                          $stable(cfg_out.vendor_identifier))
        else $error("captured identifiers changed");

    a_generic_id: assert property (@(posedge clk_in) disable iff (!rstn_in)  // see RQ1
        $rose(cfg_out.valid) && csel_q[1] |-> cfg_out.product_identifier == `HCL_GENERIC_PRODUCT)
        else $error("generic product id not reported");

endmodule // hcl_loader

//--- dv/hcl_mem_model.sv
// Behavioural three-wire serial memory answering one continuous read
`timescale 1ns/1ps

module hcl_mem_model (
    input  wire logic        rstn_in,
    input  wire logic        mem_clk_in,
    input  wire logic        dev_data_in,
    input  wire logic        dev_oe_in,
    input  wire logic        pulldown_in,
    input  wire logic [47:0] words_in,
    output logic             line_out,
    output logic [7:0]       cmd_out,
    output logic [6:0]       rises_out
);
    logic drv_q;
    logic bit_q;
    logic last_q;

    // ----------------------------------------------------------------
    // Command capture and word stream, advanced on each clock rise
    // ----------------------------------------------------------------
    always @(posedge mem_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rises_out <= 7'h00;
            cmd_out   <= 8'h00;
            drv_q     <= 1'b0;
            bit_q     <= 1'b0;
            last_q    <= 1'b0;
        end else begin
            rises_out <= rises_out + 7'h01;
            last_q    <= line_out;
            if (rises_out < 7'h08) begin
                cmd_out <= {cmd_out[6:0], line_out};
            end
            if (rises_out == 7'h07) begin
                drv_q <= 1'b1;
                bit_q <= 1'b0;
            end else if (rises_out >= 7'h08 && rises_out < 7'h38) begin
                bit_q <= words_in[6'(7'h37 - rises_out)];
            end else if (rises_out == 7'h38) begin
                drv_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wire level: device, then memory, then pulldown, else the inverse of the level seen at the last rise
    // ----------------------------------------------------------------
    always_comb begin
        if (dev_oe_in) begin
            line_out = dev_data_in;
        end else if (drv_q) begin
            line_out = bit_q;
        end else if (pulldown_in) begin
            line_out = 1'b0;
        end else begin
            line_out = ~last_q;
        end
    end
endmodule // hcl_mem_model

//--- dv/hcl_loader_bench.sv
// Self-checking bench for the hub configuration loader
`timescale 1ns/1ps
`include "hcl_defs.svh"

module hcl_loader_bench;
    logic              clk_in    = 1'b0;
    logic              link_clk  = 1'b0;
    logic              rstn_in   = 1'b0;
    logic              ext_sel   = 1'b0;
    logic              bus_pwr   = 1'b0;
    logic              clk_src   = 1'b0;
    logic              xtal      = 1'b0;
    logic              fast_pin  = 1'b0;
    logic              gang_pin  = 1'b0;
    logic [3:0]        oc_n      = 4'hF;
    logic [7:0]        reg_addr  = 8'h00;
    logic [31:0]       reg_wdata = 32'h0;
    logic              reg_write = 1'b0;
    logic              reg_read  = 1'b0;
    logic [47:0]       words     = 48'h0;
    logic [31:0]       rd_val;
    logic              d_out, d_oe, c_out, c_oe, pd, line;
    logic [3:0]        pwr_n;
    logic [31:0]       rdata;
    logic [7:0]        cmd;
    logic [6:0]        rises;
    hcl_pkg::hcl_cfg_t cfg;
    int                err_total = 0;
    int                samples_checked = 0;

    always #5 clk_in = ~clk_in;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    hcl_loader u_dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk),
        .ext_memory_select_in(ext_sel), .bus_power_select_in(bus_pwr),
        .clock_source_select_in(clk_src), .crystal_in_in(xtal), .fast_clock_input_in(fast_pin),
        .serial_mem_data_in(ext_sel ? gang_pin : line), .serial_mem_data_out(d_out),
        .serial_mem_data_oe_out(d_oe), .serial_mem_clock_out(c_out), .serial_mem_clock_oe_out(c_oe),
        .serial_mem_pulldown_en_out(pd), .overcurrent_in_n_in(oc_n), .port_power_enable_n_out(pwr_n),
        .cfg_out(cfg), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
        .reg_read_in(reg_read), .reg_rdata_out(rdata)
    );

    hcl_mem_model u_mem (
        .rstn_in(rstn_in), .mem_clk_in(c_oe & c_out), .dev_data_in(d_out), .dev_oe_in(d_oe),
        .pulldown_in(pd), .words_in(words), .line_out(line), .cmd_out(cmd), .rises_out(rises)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_in);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_in);
        reg_read <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic boot(input logic sel, input logic bus, input logic src, input logic [47:0] w);
        int n;
        @(posedge clk_in);
        rstn_in  <= 1'b0;
        ext_sel  <= sel;
        bus_pwr  <= bus;
        clk_src  <= src;
        xtal     <= src;
        fast_pin <= src;
        words    <= w;
        oc_n     <= 4'hF;
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        n = 0;
        while (cfg.valid !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            n++;
        end
        #1 check(32'(cfg.valid), 32'h1);
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #500000;
        err_total++;
        tally_and_finish;
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        boot(1'b0, 1'b1, 1'b1, {16'h4000, 16'hA55A, 16'h3CC3});
        check(32'(cmd), 32'hC0);
        check(32'(rises), 32'd57);
        check(32'(cfg.vendor_identifier), 32'hA55A);
        check(32'(cfg.product_identifier), 32'h3CC3);
        check(32'(cfg.gang), 32'h1);
        check(32'({d_oe, c_oe, pd}), 32'h1);
        reg_rd(`HCL_REG_VENDOR, rd_val);
        check(rd_val, 32'hA55A);
        settle(1);
        check(rdata, 32'h0);
        reg_wr(`HCL_REG_PRODUCT, 32'hFFFF);
        reg_rd(`HCL_REG_PRODUCT, rd_val);
        check(rd_val, 32'h3CC3);
        reg_rd(`HCL_REG_STATUS, rd_val);
        check(rd_val, 32'h3D);
        reg_rd(8'h20, rd_val);
        check(rd_val, 32'h0);
        check(32'(pwr_n), 32'hF);
        reg_wr(`HCL_REG_POWER, 32'h1);
        settle(4);
        check(32'(pwr_n), 32'h0);
        oc_n <= 4'hB;
        settle(6);
        check(32'(pwr_n), 32'hF);
        reg_rd(`HCL_REG_OCFLAG, rd_val);
        check(rd_val, 32'h4);
        oc_n <= 4'hF;
        settle(6);
        reg_wr(`HCL_REG_OCFLAG, 32'h4);
        reg_rd(`HCL_REG_OCFLAG, rd_val);
        check(rd_val, 32'h0);
        check(32'(pwr_n), 32'h0);
        settle(1500);
        check(32'(rises), 32'd57);

        boot(1'b0, 1'b0, 1'b0, {16'h0000, 16'h0102, 16'h0304});
        check(32'({cfg.gang, cfg.bus_powered, cfg.fast_clock}), 32'h0);
        reg_rd(`HCL_REG_STATUS, rd_val);
        check(rd_val, 32'h04);
        reg_wr(`HCL_REG_POWER, 32'h5);
        settle(4);
        check(32'(pwr_n), 32'hA);
        oc_n <= 4'hE;
        settle(6);
        check(32'(pwr_n), 32'hB);

        gang_pin <= 1'b1;
        boot(1'b1, 1'b1, 1'b0, 48'hFFFF_FFFF_FFFF);
        check(32'(cfg.vendor_identifier), 32'(`HCL_GENERIC_VENDOR));
        check(32'(cfg.product_identifier), 32'(`HCL_GENERIC_PRODUCT));
        check(32'({rises, d_oe, c_oe, pd}), 32'h0);
        reg_rd(`HCL_REG_STATUS, rd_val);
        check(rd_val, 32'h1E);
        gang_pin <= 1'b0;
        settle(6);
        check(32'(cfg.gang), 32'h0);
        tally_and_finish;
    end
endmodule // hcl_loader_bench
